// file: pkg/rpr_pkg.sv
// Constants and state types shared by the remappable pin routing block.
package rpr_pkg;

  // --------------------------------------------------------------------------
  // Widths and counts
  // --------------------------------------------------------------------------
  localparam int RPR_ADDR_W    = 8;
  localparam int RPR_DATA_W    = 32;
  localparam int RPR_IN_SEL_W  = 8;
  localparam int RPR_OUT_SEL_W = 6;
  localparam int RPR_MAX_PIN   = 181;
  localparam int RPR_N_PIN     = RPR_MAX_PIN + 1;
  localparam int RPR_N_IN      = 8;
  localparam int RPR_N_OUT     = 10;
  localparam int RPR_N_OREG    = 5;
  localparam int RPR_FIRST_OUT = 32;
  localparam int RPR_N_FUNC    = 64;
  localparam int RPR_SETUP_CYC = 1;

  // --------------------------------------------------------------------------
  // Register byte addresses
  // --------------------------------------------------------------------------
  localparam logic [RPR_ADDR_W-1:0] RPR_OFF_SDI      = 8'h00;
  localparam logic [RPR_ADDR_W-1:0] RPR_OFF_SS       = 8'h04;
  localparam logic [RPR_ADDR_W-1:0] RPR_OFF_SYNC1    = 8'h08;
  localparam logic [RPR_ADDR_W-1:0] RPR_OFF_SYNC2    = 8'h0c;
  localparam logic [RPR_ADDR_W-1:0] RPR_OFF_FLT56    = 8'h10;
  localparam logic [RPR_ADDR_W-1:0] RPR_OFF_FLT78    = 8'h14;
  localparam logic [RPR_ADDR_W-1:0] RPR_OFF_OUT0     = 8'h18;
  localparam logic [RPR_ADDR_W-1:0] RPR_OFF_OUT_STEP = 8'h04;

  // --------------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------------
  localparam int RPR_LO_LSB = 0;
  localparam int RPR_HI_LSB = 8;
  localparam logic [RPR_IN_SEL_W-1:0]  RPR_IN_RST  = 8'h00;
  localparam logic [RPR_OUT_SEL_W-1:0] RPR_OUT_RST = 6'h00;
  localparam logic [RPR_IN_SEL_W-1:0]  RPR_SEL_GND = 8'h00;

  // Index of each routed peripheral input in the selection array.
  localparam int RPR_IX_SDI   = 0;
  localparam int RPR_IX_SS    = 1;
  localparam int RPR_IX_SYNC1 = 2;
  localparam int RPR_IX_SYNC2 = 3;
  localparam int RPR_IX_FLT5  = 4;

  // --------------------------------------------------------------------------
  // State of the top level
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [RPR_N_IN-1:0][RPR_IN_SEL_W-1:0]   in_sel;
    logic [RPR_N_OUT-1:0][RPR_OUT_SEL_W-1:0] out_sel;
    logic                                    pready;
    logic                                    pslverr;
    logic [RPR_DATA_W-1:0]                   prdata;
  } rpr_state_t;

endpackage : rpr_pkg

// file: hdl/rpr_in_route.sv
// Registered selector that routes one remappable pin to a peripheral input.
`timescale 1ns/10ps
module rpr_in_route #(
  parameter int W    = 182,
  parameter int SELW = 8
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_rstn,
  input  wire logic [W-1:0]    i_src,
  input  wire logic [SELW-1:0] i_sel,
  output logic                 o_out
);
  import rpr_pkg::*;

  typedef struct packed {
    logic out;
  } rpr_in_state_t;

  rpr_in_state_t st;
  rpr_in_state_t next_st;

  // A source count that the selector width cannot reach is refused.
  if (W > (1 << SELW))
  begin : g_chk
    $error("rpr_in_route: source count exceeds selector range");
  end

  // ---------------------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------------------
  // Code zero and codes past the last pin tie the input low.
  always_comb
  begin
    next_st = st;
    if (i_sel == SELW'(0) || int'(i_sel) >= W)
      next_st.out = 1'b0; // RULE2
    else
      next_st.out = i_src[i_sel]; // RULE1
  end

  // Registering keeps each routed input glitch free while a field changes.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      st <= '0;
    else
      st <= next_st; // RULE13
  end

  assign o_out = st.out;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  pin_follow_a: assert property ((i_sel != 0 && int'(i_sel) < W) |=> // RULE1
    o_out == $past(i_src[i_sel])) else $error("routed input missed its pin");
  ground_tie_a: assert property ((i_sel == 0) |=> !o_out) // RULE2
    else $error("input with ground code not low");

endmodule : rpr_in_route

// file: hdl/rpr_out_route.sv
// Registered selector that routes one peripheral function to a remappable pin.
`timescale 1ns/10ps
module rpr_out_route #(
  parameter int NFUNC = 64,
  parameter int SELW  = 6
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rstn,
  input  wire logic [NFUNC-1:0] i_func,
  input  wire logic [SELW-1:0]  i_sel,
  output logic                  o_pin
);
  import rpr_pkg::*;

  typedef struct packed {
    logic pin;
  } rpr_out_state_t;

  rpr_out_state_t st;
  rpr_out_state_t next_st;

  // A function count that the selector width cannot reach is refused.
  if (NFUNC > (1 << SELW))
  begin : g_chk
    $error("rpr_out_route: function count exceeds selector range");
  end

  // ---------------------------------------------------------------------------
  // Function selection
  // ---------------------------------------------------------------------------
  // Function code zero leaves the pin at its default low level.
  always_comb
  begin
    next_st = st;
    if (i_sel == SELW'(0) || int'(i_sel) >= NFUNC)
      next_st.pin = 1'b0;
    else
      next_st.pin = i_func[i_sel]; // RULE9
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      st <= '0;
    else
      st <= next_st; // RULE13
  end

  assign o_pin = st.pin;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  func_follow_a: assert property ((i_sel != 0 && int'(i_sel) < NFUNC) |=> // RULE9
    o_pin == $past(i_func[i_sel])) else $error("output pin missed its function");

endmodule : rpr_out_route

// file: hdl/rpr_pin_routing.sv
// Remappable pin routing: APB register file, input and output pin selectors.
//
// Function
// RULE1: Eight-bit input code equals pin number.
// RULE2: Code one is pin one; zero ties low.
// RULE3: Slave-select field low byte, upper unimplemented.
// RULE4: Sync input one in upper byte only.
// RULE5: Sync input two in lower byte only.
// RULE6: Faults six high, five low, fully writable.
// RULE7: Faults eight high, seven low, fully writable.
// RULE8: Serial data input field in low byte.
// RULE9: Six-bit output codes at 13:8, 5:0.
// RULE10: Pins 32-41 paired, even pin low.
// RULE11: Unimplemented bits ignore writes, read zero.
// RULE12: Implemented fields read/write, reset to zero.
// RULE13: New selection applies from next clock.
`timescale 1ns/10ps
module rpr_pin_routing (
  input  wire logic                              i_core_clk,
  input  wire logic                              i_rstn,
  // APB slave.
  input  wire logic                              i_psel,
  input  wire logic                              i_penable,
  input  wire logic                              i_pwrite,
  input  wire logic [rpr_pkg::RPR_ADDR_W-1:0]    i_paddr,
  input  wire logic [rpr_pkg::RPR_DATA_W-1:0]    i_pwdata,
  input  wire logic [3:0]                        i_pstrb,
  output logic                                   o_pready,
  output logic [rpr_pkg::RPR_DATA_W-1:0]         o_prdata,
  output logic                                   o_pslverr,
  // Remappable pins and peripheral signals.
  input  wire logic [rpr_pkg::RPR_N_PIN-1:0]     i_remap_pin,
  input  wire logic [rpr_pkg::RPR_N_FUNC-1:0]    i_periph_func,
  output logic                                   o_spi_serial_data_input,
  output logic                                   o_spi_slave_select_input,
  output logic                                   o_pwm_sync_one,
  output logic                                   o_pwm_sync_two,
  output logic [3:0]                             o_pwm_fault_five_to_eight,
  output logic [rpr_pkg::RPR_N_OUT-1:0]          o_remap_out
);
  import rpr_pkg::*;

  rpr_state_t                       st;
  rpr_state_t                       next_st;
  logic [RPR_N_IN-1:0]              in_route;
  logic                             setup;
  logic                             wr_take;
  logic                             hit;
  logic [RPR_DATA_W-1:0]            rd;

  // ---------------------------------------------------------------------------
  // Bus phase decode
  // ---------------------------------------------------------------------------
  // Data is prepared in the setup cycle so every bus output leaves a flop.
  assign setup   = i_psel && !i_penable;
  assign wr_take = i_psel && i_penable && st.pready && i_pwrite;

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  // The map pairs two output fields per word and keeps each field inside one
  // byte lane; constants that break either layout are refused here.
  if (RPR_N_OUT != 2 * RPR_N_OREG)
  begin : g_chk_pair
    $error("rpr_pin_routing: output pins do not pair into registers");
  end
  if (RPR_IN_SEL_W > 8 || RPR_OUT_SEL_W > 8)
  begin : g_chk_lane
    $error("rpr_pin_routing: a field does not fit one byte lane");
  end
  if (RPR_N_IN != RPR_IX_FLT5 + 4)
  begin : g_chk_in
    $error("rpr_pin_routing: input count does not match the fault block");
  end

  // ---------------------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------------------
  // Reserved bits are never placed, so they read as zero.
  always_comb
  begin
    hit = 1'b0;
    rd  = '0;
    if (i_paddr == RPR_OFF_SDI)
    begin
      hit = 1'b1;
      rd[RPR_LO_LSB +: RPR_IN_SEL_W] = st.in_sel[RPR_IX_SDI]; // RULE8
    end
    else if (i_paddr == RPR_OFF_SS)
    begin
      hit = 1'b1;
      rd[RPR_LO_LSB +: RPR_IN_SEL_W] = st.in_sel[RPR_IX_SS]; // RULE3
    end
    else if (i_paddr == RPR_OFF_SYNC1)
    begin
      hit = 1'b1;
      rd[RPR_HI_LSB +: RPR_IN_SEL_W] = st.in_sel[RPR_IX_SYNC1]; // RULE4
    end
    else if (i_paddr == RPR_OFF_SYNC2)
    begin
      hit = 1'b1;
      rd[RPR_LO_LSB +: RPR_IN_SEL_W] = st.in_sel[RPR_IX_SYNC2]; // RULE5
    end
    else if (i_paddr == RPR_OFF_FLT56)
    begin
      hit = 1'b1;
      rd[RPR_LO_LSB +: RPR_IN_SEL_W] = st.in_sel[RPR_IX_FLT5]; // RULE6
      rd[RPR_HI_LSB +: RPR_IN_SEL_W] = st.in_sel[RPR_IX_FLT5+1];
    end
    else if (i_paddr == RPR_OFF_FLT78)
    begin
      hit = 1'b1;
      rd[RPR_LO_LSB +: RPR_IN_SEL_W] = st.in_sel[RPR_IX_FLT5+2]; // RULE7
      rd[RPR_HI_LSB +: RPR_IN_SEL_W] = st.in_sel[RPR_IX_FLT5+3];
    end
    else
    begin
      for (int k = 0; k < RPR_N_OREG; k++)
      begin
        if (i_paddr == RPR_OFF_OUT0 + RPR_ADDR_W'(k) * RPR_OFF_OUT_STEP)
        begin
          hit = 1'b1;
          rd[RPR_LO_LSB +: RPR_OUT_SEL_W] = st.out_sel[2*k];   // RULE10
          rd[RPR_HI_LSB +: RPR_OUT_SEL_W] = st.out_sel[2*k+1]; // RULE11
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Writes land only at the access edge; each byte lane writes one field.
  always_comb
  begin
    next_st         = st;
    next_st.pready  = setup;
    next_st.pslverr = setup && !hit;
    next_st.prdata  = (setup && !i_pwrite) ? rd : '0;
    if (wr_take)
    begin
      if (i_paddr == RPR_OFF_SDI && i_pstrb[0])
        next_st.in_sel[RPR_IX_SDI] = i_pwdata[RPR_LO_LSB +: RPR_IN_SEL_W]; // RULE8
      if (i_paddr == RPR_OFF_SS && i_pstrb[0])
        next_st.in_sel[RPR_IX_SS] = i_pwdata[RPR_LO_LSB +: RPR_IN_SEL_W]; // RULE3
      if (i_paddr == RPR_OFF_SYNC1 && i_pstrb[1])
        next_st.in_sel[RPR_IX_SYNC1] = i_pwdata[RPR_HI_LSB +: RPR_IN_SEL_W]; // RULE4
      if (i_paddr == RPR_OFF_SYNC2 && i_pstrb[0])
        next_st.in_sel[RPR_IX_SYNC2] = i_pwdata[RPR_LO_LSB +: RPR_IN_SEL_W]; // RULE5
      if (i_paddr == RPR_OFF_FLT56)
      begin
        if (i_pstrb[0])
          next_st.in_sel[RPR_IX_FLT5] = i_pwdata[RPR_LO_LSB +: RPR_IN_SEL_W]; // RULE6
        if (i_pstrb[1])
          next_st.in_sel[RPR_IX_FLT5+1] = i_pwdata[RPR_HI_LSB +: RPR_IN_SEL_W];
      end
      if (i_paddr == RPR_OFF_FLT78)
      begin
        if (i_pstrb[0])
          next_st.in_sel[RPR_IX_FLT5+2] = i_pwdata[RPR_LO_LSB +: RPR_IN_SEL_W]; // RULE7
        if (i_pstrb[1])
          next_st.in_sel[RPR_IX_FLT5+3] = i_pwdata[RPR_HI_LSB +: RPR_IN_SEL_W];
      end
      // Bits 7:6 and 15:14 are simply not stored.
      for (int k = 0; k < RPR_N_OREG; k++)
      begin
        if (i_paddr == RPR_OFF_OUT0 + RPR_ADDR_W'(k) * RPR_OFF_OUT_STEP)
        begin
          if (i_pstrb[0])
            next_st.out_sel[2*k] = i_pwdata[RPR_LO_LSB +: RPR_OUT_SEL_W]; // RULE10
          if (i_pstrb[1])
            next_st.out_sel[2*k+1] = i_pwdata[RPR_HI_LSB +: RPR_OUT_SEL_W]; // RULE11
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Reset clears every field, so inputs start grounded and outputs idle.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      st <= '0; // RULE12
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Selectors
  // ---------------------------------------------------------------------------
  // One registered selector per peripheral input; a field change moves only it.
  for (genvar g = 0; g < RPR_N_IN; g++)
  begin : g_in
    rpr_in_route #(
      .W    (RPR_N_PIN),
      .SELW (RPR_IN_SEL_W)
    ) u_in (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_src      (i_remap_pin),
      .i_sel      (st.in_sel[g]),
      .o_out      (in_route[g])
    );
  end

  // Output pin g carries pin number RPR_FIRST_OUT + g.
  for (genvar g = 0; g < RPR_N_OUT; g++)
  begin : g_out
    rpr_out_route #(
      .NFUNC (RPR_N_FUNC),
      .SELW  (RPR_OUT_SEL_W)
    ) u_out (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_func     (i_periph_func),
      .i_sel      (st.out_sel[g]),
      .o_pin      (o_remap_out[g])
    );
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Bus answers leave the state flops; routed levels leave the selector flops.
  assign o_pready                  = st.pready;
  assign o_pslverr                 = st.pslverr;
  assign o_prdata                  = st.prdata;
  assign o_spi_serial_data_input   = in_route[RPR_IX_SDI];
  assign o_spi_slave_select_input  = in_route[RPR_IX_SS];
  assign o_pwm_sync_one            = in_route[RPR_IX_SYNC1];
  assign o_pwm_sync_two            = in_route[RPR_IX_SYNC2];
  assign o_pwm_fault_five_to_eight = in_route[RPR_IX_FLT5 +: 4];

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  reset_clear_a: assert property ($past(!i_rstn) |-> // RULE12
    (st.in_sel == '0 && st.out_sel == '0 && !o_pready))
    else $error("fields not cleared by reset");

  ss_upper_zero_a: assert property ((setup && i_paddr == RPR_OFF_SS && !i_pwrite) // RULE3
    |=> o_prdata[31:8] == '0) else $error("slave-select upper byte not zero");

  sync1_low_zero_a: assert property ((setup && i_paddr == RPR_OFF_SYNC1 && !i_pwrite) // RULE4
    |=> (o_prdata[7:0] == '0 && o_prdata[15:8] == st.in_sel[RPR_IX_SYNC1]))
    else $error("sync one readback wrong");

  sync2_high_zero_a: assert property ((setup && i_paddr == RPR_OFF_SYNC2 && !i_pwrite) // RULE5
    |=> o_prdata[31:8] == '0) else $error("sync two upper byte not zero");

  flt56_write_a: assert property ((wr_take && i_paddr == RPR_OFF_FLT56 && i_pstrb[1:0] == 2'b11) // RULE6
    |=> (st.in_sel[RPR_IX_FLT5] == $past(i_pwdata[7:0])
      && st.in_sel[RPR_IX_FLT5+1] == $past(i_pwdata[15:8])))
    else $error("fault five/six write lost");

  flt78_write_a: assert property ((wr_take && i_paddr == RPR_OFF_FLT78 && i_pstrb[1:0] == 2'b11) // RULE7
    |=> (st.in_sel[RPR_IX_FLT5+2] == $past(i_pwdata[7:0])
      && st.in_sel[RPR_IX_FLT5+3] == $past(i_pwdata[15:8])))
    else $error("fault seven/eight write lost");

  sdi_write_a: assert property ((wr_take && i_paddr == RPR_OFF_SDI && i_pstrb[0]) // RULE8
    |=> ##1 o_spi_serial_data_input == ($past(i_pwdata[7:0], 2) == 8'h00 ? 1'b0 :
      ($past(i_pwdata[7:0], 2) > 8'hb5 ? 1'b0 : $past(i_remap_pin[i_pwdata[7:0]], 1))))
    else $error("serial data input not routed from new pin");

  out_pair_a: assert property ((wr_take && i_paddr == RPR_OFF_OUT0 && i_pstrb[1:0] == 2'b11) // RULE10
    |=> (st.out_sel[0] == $past(i_pwdata[5:0]) && st.out_sel[1] == $past(i_pwdata[13:8])))
    else $error("pin 32/33 pairing wrong");

  out_resv_a: assert property ((setup && !i_pwrite && i_paddr >= RPR_OFF_OUT0) // RULE11
    |=> (o_prdata[15:14] == 2'b00 && o_prdata[7:6] == 2'b00))
    else $error("reserved output bits not zero");

  bus_answer_a: assert property (setup |=> (o_pready ##1 !o_pready)) // RULE13
    else $error("bus answer timing wrong");

  // Refused accesses answer with an error and leave every field untouched.
  unmapped_err_a: assert property ((setup && !hit) // RULE11
    |=> (o_pslverr && o_prdata == '0)) else $error("unmapped access not refused");

  unmapped_write_a: assert property ((wr_take && !hit) // RULE11
    |=> (st.in_sel == $past(st.in_sel) && st.out_sel == $past(st.out_sel)))
    else $error("unmapped write changed a field");

  ss_write_a: assert property ((wr_take && i_paddr == RPR_OFF_SS && i_pstrb[0]) // RULE3
    |=> st.in_sel[RPR_IX_SS] == $past(i_pwdata[7:0]))
    else $error("slave-select write lost");

  lane_keep_a: assert property ((wr_take && i_paddr == RPR_OFF_FLT56 && !i_pstrb[1]) // RULE6
    |=> st.in_sel[RPR_IX_FLT5+1] == $past(st.in_sel[RPR_IX_FLT5+1]))
    else $error("fault six changed without its lane");

  out_last_pair_a: assert property ((wr_take && i_pstrb[1:0] == 2'b11 // RULE10
    && i_paddr == RPR_OFF_OUT0 + RPR_ADDR_W'(RPR_N_OREG - 1) * RPR_OFF_OUT_STEP)
    |=> (st.out_sel[RPR_N_OUT-2] == $past(i_pwdata[5:0])
      && st.out_sel[RPR_N_OUT-1] == $past(i_pwdata[13:8])))
    else $error("pin 40/41 pairing wrong");

endmodule : rpr_pin_routing

// file: bench/rpr_far_model.sv
// Behavioural stand-in for the package pins and the peripheral output functions.
`timescale 1ns/10ps
module rpr_far_model (
  input  wire logic                            i_core_clk,
  input  wire logic [31:0]                     i_noise,
  output logic      [rpr_pkg::RPR_N_PIN-1:0]  o_pins,
  output logic      [rpr_pkg::RPR_N_FUNC-1:0] o_funcs
);
  import rpr_pkg::*;

  // --------------------------------------------------------------------------
  // Pin and function levels
  // --------------------------------------------------------------------------
  // Every level moves each cycle, so a selector that lags or picks a neighbour shows at once.
  // Fresh noise enters at the bottom and the older bits shift upward; the levels are
  // unknown only until the noise has filled them, well inside the reset time.
  always @(posedge i_core_clk)
  begin
    o_pins  <= {o_pins[RPR_N_PIN-33:0], i_noise};
    o_funcs <= {o_funcs[RPR_N_FUNC-33:0], ~i_noise};
  end
endmodule : rpr_far_model

// file: bench/remappable_pin_routing_test.sv
// Self-checking bench for the remappable pin routing block.
`timescale 1ns/10ps
module remappable_pin_routing_test;
  import rpr_pkg::*;

`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e); end end

  // --------------------------------------------------------------------------
  // Signals and bench state
  // --------------------------------------------------------------------------
  logic                  i_core_clk, i_rstn, i_psel, i_penable, i_pwrite;
  logic [RPR_ADDR_W-1:0] i_paddr;
  logic [RPR_DATA_W-1:0] i_pwdata, o_prdata;
  logic [3:0]            i_pstrb, o_flt;
  logic                  o_pready, o_pslverr, o_sdi, o_ss, o_sync1, o_sync2;
  logic [RPR_N_OUT-1:0]  o_out, exp_out;
  logic [RPR_N_PIN-1:0]  pins;
  logic [RPR_N_FUNC-1:0] funcs;
  logic [31:0]           noise, rnd;
  logic [15:0]           mreg [0:10];
  logic [7:0]            exp_in;
  logic [7:0]            codes [0:6] = '{8'h00, 8'h01, 8'h02, 8'hb4, 8'hb5, 8'hb6, 8'hff};
  int                    err_total, tests_run;
  bit                    chk_on;

  rpr_far_model far (.i_core_clk(i_core_clk), .i_noise(noise), .o_pins(pins),
                     .o_funcs(funcs));

  rpr_pin_routing uut (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_remap_pin(pins), .i_periph_func(funcs), .o_spi_serial_data_input(o_sdi),
    .o_spi_slave_select_input(o_ss), .o_pwm_sync_one(o_sync1), .o_pwm_sync_two(o_sync2),
    .o_pwm_fault_five_to_eight(o_flt), .o_remap_out(o_out));

  // --------------------------------------------------------------------------
  // Model helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Writable bits of each register; everything else must stay zero.
  function automatic logic [15:0] impl_mask(input int i);
    if (i == 2)
      return 16'hff00;
    if (i == 4 || i == 5)
      return 16'hffff;
    return (i < 4) ? 16'h00ff : 16'h3f3f;
  endfunction : impl_mask

  function automatic logic route_in(input logic [7:0] c);
    return (c == 8'h00 || c > 8'hb5) ? 1'b0 : pins[c];
  endfunction : route_in

  function automatic logic route_out(input logic [5:0] c);
    return (c == 6'h00) ? 1'b0 : funcs[c];
  endfunction : route_out

  task automatic test_done(input string name);
    $display("test %s done, %0d mismatches so far", name, err_total);
  endtask : test_done

  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // One APB transfer; the bench model follows a write only when it is taken.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int          n;
    logic        ok;
    logic [15:0] m;
    ok = (a[1:0] == 2'b00) && (a < 8'h2c);
    @(posedge i_core_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= d;
    i_pstrb   <= s;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (o_pready !== 1'b1)
    begin
      err_total++;
      $display("MISMATCH t=%0t no ready", $time);
      end_of_test();
    end
    `CHK(o_pslverr, !ok, "slave error")
    if (!wr)
      `CHK(o_prdata, ok ? {16'h0000, mreg[a[7:2]]} : 32'h0000_0000, "read")
    else if (ok)
    begin
      m = impl_mask(a[7:2]) & {{8{s[1]}}, {8{s[0]}}};
      mreg[a[7:2]] = (mreg[a[7:2]] & ~m) | (d[15:0] & m);
    end
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : acc

  // --------------------------------------------------------------------------
  // Clock, noise and routing monitor
  // --------------------------------------------------------------------------
  initial
  begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk)
    noise <= xs(noise);

  // Expectation is taken mid-cycle, from the fields and sources the next edge samples.
  always @(negedge i_core_clk)
  begin
    exp_in = {route_in(mreg[5][15:8]), route_in(mreg[5][7:0]), route_in(mreg[4][15:8]),
              route_in(mreg[4][7:0]), route_in(mreg[3][7:0]), route_in(mreg[2][15:8]),
              route_in(mreg[1][7:0]), route_in(mreg[0][7:0])};
    for (int g = 0; g < RPR_N_OUT; g++)
      exp_out[g] = route_out(g[0] ? mreg[6 + g / 2][13:8] : mreg[6 + g / 2][5:0]);
  end

  always @(posedge i_core_clk)
  begin
    #1;
    if (chk_on)
    begin
      `CHK(o_sdi, exp_in[0], "data in route")
      `CHK(o_ss, exp_in[1], "select route")
      `CHK(o_sync1, exp_in[2], "sync one route")
      `CHK(o_sync2, exp_in[3], "sync two route")
      `CHK(o_flt, exp_in[7:4], "fault routes")
      `CHK(o_out, exp_out, "output routes")
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb} = '0;
    i_rstn    = 1'b0;
    noise     = 32'h0001_6858;
    rnd       = 32'h0001_6858;
    err_total = 0;
    tests_run = 0;
    foreach (mreg[i])
      mreg[i] = 16'h0000;
    repeat (20) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    chk_on = 1'b1;
    // Reset values, plus refused accesses above the map.
    for (int i = 0; i < 12; i++)
      acc(1'b0, 8'(4 * i), 32'h0000_0000, 4'hf);
    acc(1'b1, 8'hfc, 32'hffff_ffff, 4'hf);
    test_done("reset values");
    // All ones everywhere; unimplemented bits must read back as zero.
    for (int i = 0; i < 11; i++)
    begin
      acc(1'b1, 8'(4 * i), 32'hffff_ffff, 4'hf);
      acc(1'b0, 8'(4 * i), 32'h0000_0000, 4'hf);
    end
    test_done("write ones");
    // Boundary input codes: ground, first pin, last pin, one past the last.
    foreach (codes[k])
    begin
      for (int i = 0; i < 6; i++)
        acc(1'b1, 8'(4 * i), {16'h0000, codes[k], codes[k]}, 4'h3);
      repeat (4) @(posedge i_core_clk);
    end
    test_done("input codes");
    // Random mix of reads, writes, partial strobes and an unmapped slot.
    for (int n = 0; n < 120; n++)
    begin
      rnd = xs(rnd);
      acc(rnd[31], 8'(4 * (rnd[27:24] % 12)), xs(rnd), rnd[3:0]);
    end
    test_done("random traffic");
    // A second reset in mid-run must clear every field again.
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    foreach (mreg[i])
      mreg[i] = 16'h0000;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 11; i++)
      acc(1'b0, 8'(4 * i), 32'h0000_0000, 4'hf);
    test_done("second reset");
    end_of_test();
  end
endmodule : remappable_pin_routing_test
